// file: verilog/pio_pkg.sv
// package for the parallel handshake port: map, fields, resets, timing
// assumes a 100 MHz system clock and a 16-bit host word
package pio_pkg;

	// data path width of both registers and the device lines
	localparam int DATA_W = 16;
	localparam int ADDR_W = 4;

	// register word addresses
	localparam logic [3:0] ADDR_CMD    = 4'h0;
	localparam logic [3:0] ADDR_CFG    = 4'h1;
	localparam logic [3:0] ADDR_OUT    = 4'h2;
	localparam logic [3:0] ADDR_IN     = 4'h3;
	localparam logic [3:0] ADDR_STATUS = 4'h4;
	localparam logic [3:0] ADDR_MASK   = 4'h5;

	// command word bit positions (write one to act)
	localparam int CMD_SET_CONTROL   = 0;
	localparam int CMD_CLEAR_FLAG    = 1;
	localparam int CMD_CLEAR_CONTROL = 2;
	localparam int CMD_SYSTEM_CLEAR  = 3;

	// status and mask bit positions
	localparam int ST_W       = 3;
	localparam int ST_SERVICE = 0;
	localparam int ST_CAPTURE = 1;
	localparam int ST_DONE    = 2;
	localparam logic [ST_W-1:0] STATUS_RESET = 3'h0;
	localparam logic [ST_W-1:0] MASK_RESET   = 3'h0;

	// command output forms
	localparam logic [1:0] FORM_LEVEL_HIGH = 2'h0;
	localparam logic [1:0] FORM_LEVEL_LOW  = 2'h1;
	localparam logic [1:0] FORM_PULSE_LOW  = 2'h2;

	// strap word, msb first
	localparam int CFG_W = 10;
	typedef struct packed {
		logic       bus_mode;
		logic       gated_output;
		logic       gated_input;
		logic       done_edge_fall;
		logic       set_edge_fall;
		logic       done_clears_cmd;
		logic       edge_sets_flag;
		logic       ones_high;
		logic [1:0] cmd_form;
	} pio_cfg_t;
	localparam logic [CFG_W-1:0] CFG_RESET = 10'h198;

	// register bus request
	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} pio_bus_req_t;

	// command pulse states
	typedef enum logic [0:0] {PULSE_IDLE, PULSE_LOW} pio_pulse_t;

	// timing
	localparam int CLK_PERIOD_NS    = 10;
	localparam int CMD_PULSE_NS     = 300;
	localparam int CMD_PULSE_CYCLES =
		(CMD_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HOST_CYCLE_NS     = 80;
	localparam int HOST_CYCLE_CYCLES = HOST_CYCLE_NS / CLK_PERIOD_NS;
	localparam int PHASE_T2          = 1;
	localparam int PHASE_T4          = 3;

endpackage

// file: verilog/pio_sync.sv
// two-flop synchroniser for pins entering the clock domain
// assumes inputs are asynchronous levels
`timescale 1ns/10ps
module pio_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         reset_n,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	logic [W-1:0] stage1;

	// first stage feeds only the second
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			stage1   <= '0;
			sync_out <= '0;
		end else begin
			stage1   <= async_in;
			sync_out <= stage1;
		end
	end
endmodule // pio_sync

// file: verilog/pio_phase.sv
// host cycle phase divider: one-cycle enables for the T2 and T4 phases
// assumes one system clock, synchronous reset
`timescale 1ns/10ps
module pio_phase (
	input  wire logic clk,
	input  wire logic reset_n,
	output logic      phase_t2,
	output logic      phase_t4
);
	logic [7:0] step;

	// step counter over one host cycle
	always_ff @(posedge clk) begin
		if (!reset_n)
			step <= 8'h00;
		else if (step == 8'(pio_pkg::HOST_CYCLE_CYCLES - 1))
			step <= 8'h00;
		else
			step <= step + 8'h01;
	end

	// phase pulses, one cycle each
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			phase_t2 <= 1'b0;
			phase_t4 <= 1'b0;
		end else begin
			phase_t2 <= (step == 8'(pio_pkg::PHASE_T2));
			phase_t4 <= (step == 8'(pio_pkg::PHASE_T4));
		end
	end
endmodule // pio_phase

// file: verilog/pio_port.sv
// parallel handshake port: two 16-bit registers, command and flag
// handshake with an external logic device, strap word, interrupts
// assumes a host on the same clock driving the plain register port
`timescale 1ns/10ps

// Behaviour
// - separate independent 16-bit output and input registers
// - data lines low-true or high-true, chosen by a strap bit
// - drive command to device; device flag reports action done
// - command form: high level, low level, or low pulse
// - chosen flag edge raises service request and/or clears command
// - without input gating the input register follows the lines
// - input-only, output-only and combined transfers all work
// - bus variant shares one bidirectional 16-bit data bus
// - set control sets command and control; clear flag clears flags
// - flag set from buffer at T2; request only if no higher priority
// - output register loads at T4 and changes without returning zero
// - gated output shows data after command; ungated: always enabled, but never enabled in bus mode
module pio_port (
	input  wire logic                        clk,
	input  wire logic                        reset_n,
	input  wire pio_pkg::pio_bus_req_t       bus,
	output logic [pio_pkg::DATA_W-1:0]       rdata,
	output logic                             irq,
	output logic [pio_pkg::DATA_W-1:0]       dev_data_out,
	output logic                             dev_data_oe,
	input  wire logic [pio_pkg::DATA_W-1:0]  dev_data_in,
	output logic                             dev_cmd,
	input  wire logic                        dev_flag,
	input  wire logic                        prio_in,
	output logic                             prio_out
);
	localparam int W = pio_pkg::DATA_W;
	localparam int ST_BITS = pio_pkg::ST_W;

	// edge selector used for both flag paths
	function automatic logic edge_hit(input logic fall,
		input logic now, input logic prev);
		edge_hit = fall ? (prev & ~now) : (now & ~prev);
	endfunction

	// address match used by write decode
	function automatic logic hit(input logic [pio_pkg::ADDR_W-1:0] a,
		input logic [pio_pkg::ADDR_W-1:0] b);
		hit = (a == b);
	endfunction

	// synchronised pins and phase enables
	logic [W+1:0]            pins_sync;
	logic [W-1:0]            data_sync;
	logic                    flag_sync;
	logic                    prio_sync;
	logic                    flag_prev;
	logic                    phase_t2;
	logic                    phase_t4;

	// straps and handshake flip-flops
	pio_pkg::pio_cfg_t       cfg;
	logic                    control;
	logic                    cmd_ff;
	logic                    flag_buf;
	logic                    flag;
	logic                    svc_prev;

	// data registers
	logic [W-1:0]            in_reg;
	logic [W-1:0]            out_reg;
	logic [W-1:0]            out_hold;
	logic                    out_pending;

	// interrupt state and pulse sequencer
	logic [ST_BITS-1:0]      status;
	logic [ST_BITS-1:0]      mask;
	pio_pkg::pio_pulse_t     pulse_state;
	logic [7:0]              pulse_count;

	// decoded host commands, flag edges, pulse and interrupt terms
	logic wr_cmd;
	logic set_control_cmd;
	logic clear_flag_cmd;
	logic clear_control_cmd;
	logic system_clear;
	logic host_output_strobe;
	logic set_edge;
	logic done_edge;
	logic done_fires;
	logic svc;
	logic capture;
	logic pulse_mode;
	logic pulse_end;
	logic [ST_BITS-1:0] events;
	logic [ST_BITS-1:0] w1c;
	logic [ST_BITS-1:0] next_status;

	// pins into the clock domain
	pio_sync #(
		.W (W + 2)
	) u_sync (
		.clk      (clk),
		.reset_n  (reset_n),
		.async_in ({prio_in, dev_flag, dev_data_in}),
		.sync_out (pins_sync)
	);
	assign data_sync = pins_sync[W-1:0];
	assign flag_sync = pins_sync[W];
	assign prio_sync = pins_sync[W+1];

	// host cycle phases
	pio_phase u_phase (
		.clk      (clk),
		.reset_n  (reset_n),
		.phase_t2 (phase_t2),
		.phase_t4 (phase_t4)
	);

	// register port decode
	assign wr_cmd = bus.wr & hit(bus.addr, pio_pkg::ADDR_CMD);
	assign set_control_cmd   = wr_cmd & bus.wdata[pio_pkg::CMD_SET_CONTROL];
	assign clear_flag_cmd    = wr_cmd & bus.wdata[pio_pkg::CMD_CLEAR_FLAG];
	assign clear_control_cmd =
		wr_cmd & bus.wdata[pio_pkg::CMD_CLEAR_CONTROL];
	assign system_clear = wr_cmd & bus.wdata[pio_pkg::CMD_SYSTEM_CLEAR];
	assign host_output_strobe = bus.wr & hit(bus.addr, pio_pkg::ADDR_OUT);

	// flag edges, each on its own strap
	assign set_edge  = edge_hit(cfg.set_edge_fall, flag_sync, flag_prev);
	assign done_edge = edge_hit(cfg.done_edge_fall, flag_sync, flag_prev);
	assign done_fires = done_edge & cfg.done_clears_cmd & cmd_ff;
	assign pulse_mode = cfg.cmd_form[1];
	assign pulse_end  = (pulse_state == pio_pkg::PULSE_LOW) &&
		(pulse_count == 8'h00);

	// service request gated by control and the priority chain
	assign svc = control & flag & ~prio_sync;
	assign capture = set_edge & cfg.gated_input;

	// flag history for edge detection
	always_ff @(posedge clk) begin
		if (!reset_n)
			flag_prev <= 1'b0;
		else
			flag_prev <= flag_sync;
	end

	// strap word
	always_ff @(posedge clk) begin
		if (!reset_n)
			cfg <= pio_pkg::CFG_RESET;
		else if (bus.wr && hit(bus.addr, pio_pkg::ADDR_CFG))
			cfg <= bus.wdata[pio_pkg::CFG_W-1:0];
	end

	// control flip-flop, enables the service request
	always_ff @(posedge clk) begin
		if (!reset_n || system_clear)
			control <= 1'b0;
		else if (set_control_cmd)
			control <= 1'b1;
		else if (clear_control_cmd)
			control <= 1'b0;
	end

	// command flip-flop; a new set beats a same-cycle finish
	always_ff @(posedge clk) begin
		if (!reset_n || system_clear)
			cmd_ff <= 1'b0;
		else if (set_control_cmd)
			cmd_ff <= 1'b1;
		else if (done_fires || clear_control_cmd)
			cmd_ff <= 1'b0;
		else if (pulse_mode && pulse_end)
			cmd_ff <= 1'b0;
	end

	// low pulse sequencer for the shared-line command form
	always_ff @(posedge clk) begin
		if (!reset_n || system_clear) begin
			pulse_state <= pio_pkg::PULSE_IDLE;
			pulse_count <= 8'h00;
		end else begin
			case (pulse_state)
				pio_pkg::PULSE_IDLE: begin
					if (set_control_cmd && pulse_mode) begin
						pulse_state <= pio_pkg::PULSE_LOW;
						pulse_count <= 8'(pio_pkg::CMD_PULSE_CYCLES);
					end
				end
				pio_pkg::PULSE_LOW: begin
					if (pulse_end || done_fires)
						pulse_state <= pio_pkg::PULSE_IDLE;
					pulse_count <= pulse_count - 8'h01;
				end
				default: begin
					pulse_state <= pio_pkg::PULSE_IDLE;
					pulse_count <= 8'h00;
				end
			endcase
		end
	end

	// flag buffer: device edge wins over a same-cycle clear
	always_ff @(posedge clk) begin
		if (!reset_n || system_clear)
			flag_buf <= 1'b0;
		else if (set_edge && cfg.edge_sets_flag)
			flag_buf <= 1'b1;
		else if (clear_flag_cmd)
			flag_buf <= 1'b0;
	end

	// host-visible flag, loaded from the buffer at T2
	always_ff @(posedge clk) begin
		if (!reset_n || system_clear)
			flag <= 1'b0;
		else if (phase_t2 && flag_buf)
			flag <= 1'b1;
		else if (clear_flag_cmd)
			flag <= 1'b0;
	end

	// priority chain out and request history
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			prio_out <= 1'b0;
			svc_prev <= 1'b0;
		end else begin
			prio_out <= svc | prio_sync;
			svc_prev <= svc;
		end
	end

	// input register: strobed by the flag edge or free following
	always_ff @(posedge clk) begin
		if (!reset_n)
			in_reg <= '0;
		else if (!cfg.gated_input || capture)
			in_reg <= cfg.ones_high ? data_sync : ~data_sync;
	end

	// output word waits for the T4 phase, then replaces the old word
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			out_hold    <= '0;
			out_pending <= 1'b0;
			out_reg     <= '0;
		end else begin
			if (host_output_strobe) begin
				out_hold    <= bus.wdata;
				out_pending <= 1'b1;
			end else if (phase_t4) begin
				out_pending <= 1'b0;
			end
			if (phase_t4 && out_pending)
				out_reg <= out_hold;
		end
	end

	// device data pins and their enable
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			dev_data_out <= '0;
			dev_data_oe  <= 1'b0;
		end else begin
			dev_data_out <= cfg.ones_high ? out_reg : ~out_reg;
			if (cfg.bus_mode)
				dev_data_oe <= cfg.gated_output & cmd_ff;
			else
				dev_data_oe <= ~cfg.gated_output | cmd_ff;
		end
	end

	// command pin in the strapped form
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			dev_cmd <= 1'b0;
		end else begin
			case (cfg.cmd_form)
				pio_pkg::FORM_LEVEL_HIGH: dev_cmd <= cmd_ff;
				pio_pkg::FORM_LEVEL_LOW:  dev_cmd <= ~cmd_ff;
				default: dev_cmd <= ~((pulse_state == pio_pkg::PULSE_LOW) &
					~pulse_end);
			endcase
		end
	end

	// interrupt events and write-one-to-clear
	assign events[pio_pkg::ST_SERVICE] = svc & ~svc_prev;
	assign events[pio_pkg::ST_CAPTURE] = capture;
	assign events[pio_pkg::ST_DONE]    = done_fires;
	assign w1c = (bus.wr && hit(bus.addr, pio_pkg::ADDR_STATUS)) ?
		bus.wdata[ST_BITS-1:0] : '0;

	// next status word, shared by the register and the request
	assign next_status = (status & ~w1c) | events;

	// sticky status, a new event beats its clear
	always_ff @(posedge clk) begin
		if (!reset_n)
			status <= pio_pkg::STATUS_RESET;
		else
			status <= next_status;
	end

	// interrupt mask
	always_ff @(posedge clk) begin
		if (!reset_n)
			mask <= pio_pkg::MASK_RESET;
		else if (bus.wr && hit(bus.addr, pio_pkg::ADDR_MASK))
			mask <= bus.wdata[ST_BITS-1:0];
	end

	// interrupt level output
	always_ff @(posedge clk) begin
		if (!reset_n)
			irq <= 1'b0;
		else
			irq <= |(next_status & mask);
	end

	// read data, valid only in the cycle after the strobe
	always_ff @(posedge clk) begin
		if (!reset_n || !bus.rd) begin
			rdata <= '0;
		end else begin
			case (bus.addr)
				pio_pkg::ADDR_CMD:
					rdata <= {12'h000, flag_buf, flag, control, cmd_ff};
				pio_pkg::ADDR_CFG:
					rdata <= {6'h00, cfg};
				pio_pkg::ADDR_OUT:
					rdata <= out_reg;
				pio_pkg::ADDR_IN:
					rdata <= in_reg;
				pio_pkg::ADDR_STATUS:
					rdata <= {13'h0000, status};
				pio_pkg::ADDR_MASK:
					rdata <= {13'h0000, mask};
				default:
					rdata <= '0;
			endcase
		end
	end
endmodule // pio_port

// file: verif/pio_port_properties.sv
// assertions on the parallel port pins, mirror of straps and mask
// assumes it is bound to pio_port with default straps out of reset
`timescale 1ns/10ps
module pio_port_properties (
	input wire logic                  clk,
	input wire logic                  reset_n,
	input wire pio_pkg::pio_bus_req_t bus,
	input wire logic [15:0]           rdata,
	input wire logic                  irq,
	input wire logic [15:0]           dev_data_out,
	input wire logic                  dev_data_oe,
	input wire logic                  dev_cmd,
	input wire logic                  dev_flag,
	input wire logic                  prio_in,
	input wire logic                  prio_out
);
	pio_pkg::pio_cfg_t sh;
	logic [2:0]        msk;
	logic [15:0]       lo;
	logic              wc;
	logic              set;
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	// mirror of straps, mask and last output word
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			sh <= pio_pkg::CFG_RESET;
			msk <= '0;
			lo <= '0;
		end else if (bus.wr) begin
			if (bus.addr == pio_pkg::ADDR_CFG) sh <= bus.wdata[9:0];
			if (bus.addr == pio_pkg::ADDR_MASK) msk <= bus.wdata[2:0];
			if (bus.addr == pio_pkg::ADDR_OUT) lo <= bus.wdata;
		end
	end
	// command writes
	assign wc = bus.wr && bus.addr == pio_pkg::ADDR_CMD;
	assign set = wc && bus.wdata[0] && !bus.wdata[3];
	sequence low8_s;
		(!dev_cmd) [*8];
	endsequence
	// thirty low cycles, then back high
	sequence pulse_s;
		low8_s ##1 low8_s ##1 low8_s ##1 (!dev_cmd) [*6] ##1 dev_cmd;
	endsequence
	rdata_idle_a: assert property (!bus.rd |=> rdata == '0)
		else $error("read data not idle");
	cmd_start_a: assert property (set |-> ##2
		dev_cmd == (sh.cmd_form == pio_pkg::FORM_LEVEL_HIGH))
		else $error("command level wrong");
	pulse_shape_a: assert property (set && sh.cmd_form[1]
		|-> ##2 pulse_s) else $error("command pulse wrong");
	sys_clear_a: assert property (wc && bus.wdata[3]
		&& sh.cmd_form == 2'h0 |-> ##2 !dev_cmd)
		else $error("command kept after clear");
	flag_clear_a: assert property ($rose(dev_flag) && dev_cmd
		&& sh.cmd_form == 2'h0 && sh.done_clears_cmd
		&& !sh.done_edge_fall |-> ##[2:6] !dev_cmd)
		else $error("flag did not end command");
	irq_mask_a: assert property (msk == '0 && $past(msk) == '0
		|-> !irq) else $error("masked interrupt");
	prio_pass_a: assert property (prio_in [*4] |=> prio_out)
		else $error("priority not passed");
	oe_free_a: assert property (!sh.gated_output && !sh.bus_mode
		|=> dev_data_oe) else $error("output not enabled");
	out_load_a: assert property (bus.wr &&
		bus.addr == pio_pkg::ADDR_OUT |=> ##[0:11]
		dev_data_out == (sh.ones_high ? lo : ~lo))
		else $error("output word not shown");
endmodule // pio_port_properties
bind pio_port pio_port_properties chk (.clk(clk), .reset_n(reset_n),
	.bus(bus), .rdata(rdata), .irq(irq), .dev_data_out(dev_data_out),
	.dev_data_oe(dev_data_oe), .dev_cmd(dev_cmd), .dev_flag(dev_flag),
	.prio_in(prio_in), .prio_out(prio_out));

// file: verif/pio_dev_model.sv
// external logic device: answers a held command with a done flag
// assumes the bench tells it the active level and the delay
`timescale 1ns/10ps
module pio_dev_model (
	input wire logic        clk,
	input wire logic        dev_cmd,
	input wire logic        act_low,
	input wire logic [15:0] delay,
	input wire logic [15:0] resp,
	output logic            dev_flag,
	output logic [15:0]     dev_data_in
);
	logic [15:0] cnt = '0;
	logic [5:0]  hold = '0;
	initial dev_flag = 1'b0;
	assign dev_data_in = resp; // data lines always driven
	// count while commanded, then hold the flag up 32 cycles
	always @(posedge clk) begin
		cnt <= (dev_cmd ^ act_low) ? cnt + 16'h1 : 16'h0;
		if (hold != 6'h0) begin
			hold <= hold - 6'h1;
			dev_flag <= (hold != 6'h1);
		end else if (cnt == delay && (dev_cmd ^ act_low)) begin
			dev_flag <= 1'b1; // action done report
			hold <= 6'h20;
		end
	end
endmodule // pio_dev_model

// file: verif/testbench.sv
// self-checking bench for the parallel handshake port
// assumes the device model and bound checker beside the design
`timescale 1ns/10ps
module testbench;
	logic                  clk = 1'b0;
	logic                  reset_n, prio_in, prio_out, act_low;
	logic                  irq, oe, dcmd, dflag, rd_d;
	pio_pkg::pio_bus_req_t bus;
	logic [15:0]           rdata, dout, din, delay, resp, v;
	int                    fails, num_checks, i;
	int                    cyc = 0;
	logic [15:0]           eq[$];
	string                 nq[$];
	pio_port uut (.clk(clk), .reset_n(reset_n), .bus(bus), .rdata(rdata),
		.irq(irq), .dev_data_out(dout), .dev_data_oe(oe),
		.dev_data_in(din), .dev_cmd(dcmd), .dev_flag(dflag),
		.prio_in(prio_in), .prio_out(prio_out));
	pio_dev_model dev (.clk(clk), .dev_cmd(dcmd), .act_low(act_low),
		.delay(delay), .resp(resp), .dev_flag(dflag), .dev_data_in(din));
	always #5 clk = ~clk;
	task automatic give_verdict;
		if (fails == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic check(string n, logic [15:0] e, logic [15:0] g);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("unexpected %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic tick(int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask
	task automatic wr(logic [3:0] a, logic [15:0] d);
		@(posedge clk);
		bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk);
		bus <= '0;
	endtask
	task automatic rd(logic [3:0] a, logic [15:0] e, string n);
		@(posedge clk);
		bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0};
		eq.push_back(e);
		nq.push_back(n);
		@(posedge clk);
		bus <= '0;
	endtask
	// read results, oldest note first; hang ceiling
	always @(posedge clk) begin
		rd_d <= bus.rd;
		if (rd_d === 1'b1) check(nq.pop_front(), eq.pop_front(), rdata);
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails++;
			give_verdict;
		end
	end
	// main sequence
	initial begin
		fails = 0;
		num_checks = 0;
		bus = '0;
		prio_in = 1'b0;
		act_low = 1'b0;
		delay = 16'd300;
		resp = 16'h0;
		reset_n = 1'b0;
		v = 16'($urandom(89));
		repeat (4) @(posedge clk);
		reset_n <= 1'b1;
		rd(pio_pkg::ADDR_CFG, 16'(pio_pkg::CFG_RESET), "cfg");
		rd(pio_pkg::ADDR_CMD, 16'h0, "cmd");
		rd(pio_pkg::ADDR_MASK, 16'h0, "mask");
		rd(4'hf, 16'h0, "unmapped");
		wr(pio_pkg::ADDR_CMD, 16'h0003);
		tick(3);
		check("cmd_pin", 16'h1, {15'h0, dcmd});
		rd(pio_pkg::ADDR_CMD, 16'h0003, "cmd");
		wr(pio_pkg::ADDR_CMD, 16'h0008);
		rd(pio_pkg::ADDR_CMD, 16'h0000, "cmd");
		// output word, then a full handshake with the device
		v = 16'($urandom);
		@(posedge clk) resp <= 16'($urandom);
		wr(pio_pkg::ADDR_OUT, v);
		tick(12);
		check("dout", ~v, dout);
		rd(pio_pkg::ADDR_OUT, v, "out");
		wr(pio_pkg::ADDR_MASK, 16'h0001);
		delay = 16'd10;
		wr(pio_pkg::ADDR_CMD, 16'h0003);
		for (i = 0; i < 200 && irq !== 1'b1; i++) @(posedge clk);
		tick(1);
		check("irq", 16'h1, {15'h0, irq});
		check("cmd_pin", 16'h0, {15'h0, dcmd});
		rd(pio_pkg::ADDR_CMD, 16'h000e, "cmd");
		rd(pio_pkg::ADDR_STATUS, 16'h0007, "status");
		rd(pio_pkg::ADDR_IN, ~resp, "in");
		// masked: status stays set, request drops, then returns
		wr(pio_pkg::ADDR_MASK, 16'h0000);
		tick(3);
		check("irq", 16'h0, {15'h0, irq});
		wr(pio_pkg::ADDR_MASK, 16'h0001);
		tick(3);
		check("irq", 16'h1, {15'h0, irq});
		wr(pio_pkg::ADDR_STATUS, 16'h0007);
		tick(3);
		check("irq", 16'h0, {15'h0, irq});
		wr(pio_pkg::ADDR_CMD, 16'h0002);
		rd(pio_pkg::ADDR_CMD, 16'h0002, "cmd");
		@(posedge clk) prio_in <= 1'b1;
		tick(5);
		check("prio", 16'h1, {15'h0, prio_out});
		@(posedge clk) prio_in <= 1'b0;
		tick(5);
		check("prio", 16'h0, {15'h0, prio_out});
		// high-true lines; input follows the pins with no flag
		wr(pio_pkg::ADDR_CFG, 16'h011c);
		for (i = 0; i < 3; i++) begin
			@(posedge clk) resp <= 16'($urandom);
			tick(6);
			rd(pio_pkg::ADDR_IN, resp, "in");
		end
		// ungated output shows the word at once
		wr(pio_pkg::ADDR_CFG, 16'h001c);
		v = 16'($urandom);
		wr(pio_pkg::ADDR_OUT, v);
		tick(12);
		check("oe", 16'h1, {15'h0, oe});
		check("dout", v, dout);
		// each command form: idle, active and late level
		delay = 16'hffff;
		for (i = 0; i < 3; i++) begin
			act_low = (i != 0);
			wr(pio_pkg::ADDR_CMD, 16'h0008);
			wr(pio_pkg::ADDR_CFG, 16'h019c | 16'(i));
			tick(3);
			check("idle", 16'(i != 0), {15'h0, dcmd});
			wr(pio_pkg::ADDR_CMD, 16'h0001);
			tick(3);
			check("act", 16'(i == 0), {15'h0, dcmd});
			check("oe", 16'h1, {15'h0, oe});
			tick(40);
			check("late", 16'(i != 1), {15'h0, dcmd});
		end
		// bus variant: shared lines driven only while commanded
		wr(pio_pkg::ADDR_CFG, 16'h039c);
		tick(3);
		check("oe", 16'h0, {15'h0, oe});
		wr(pio_pkg::ADDR_CMD, 16'h0001);
		tick(3);
		check("oe", 16'h1, {15'h0, oe});
		wr(pio_pkg::ADDR_CMD, 16'h0004);
		tick(3);
		check("oe", 16'h0, {15'h0, oe});
		rd(pio_pkg::ADDR_CMD, 16'h0000, "cmd");
		tick(3);
		give_verdict;
	end
endmodule // testbench
